//--- logic/event_reg_pkg.sv
package event_reg_pkg;
    // -----------------------------------------------
    // register port
    // -----------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_EVENT_SET = 8'h80;
    localparam logic [7:0] OFS_EVENT_CLR = 8'h84;
    localparam logic [31:0] EVENT_RESET = 32'h0000_0000;

    // -----------------------------------------------
    // event bit positions
    // -----------------------------------------------
    localparam int EV_LO = 21;
    localparam int EV_HI = 26;
    localparam int EV_N = EV_HI - EV_LO + 1;
    localparam int BIT_SIXTY_FOUR = 21;
    localparam int BIT_MISSING = 22;
    localparam int BIT_MISMATCH = 23;
    localparam int BIT_FATAL = 24;
    localparam int BIT_OVERLONG = 25;
    localparam int BIT_PHY_REG = 26;

    // -----------------------------------------------
    // cycle timer fields
    // -----------------------------------------------
    localparam int SECONDS_W = 7;
    localparam int COUNT_W = 13;
    localparam int SECONDS_ROLL_BIT = 6;

    // -----------------------------------------------
    // overlong cycle timer
    // -----------------------------------------------
    localparam longint CLK_HZ = 64'd200_000_000;
    localparam longint OVERLONG_MIN_S = 64'd115;
    localparam longint OVERLONG_MAX_S = 64'd120;
    localparam longint OVERLONG_CYCLES = OVERLONG_MIN_S * CLK_HZ;
    localparam int OVERLONG_CNT_W = 40;
endpackage

//--- logic/rise_detect.sv
`timescale 1ns/1ps
module rise_detect #(
    parameter int WIDTH = 6
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    input wire logic [WIDTH-1:0] level,
    output logic [WIDTH-1:0] rise
);
    // -----------------------------------------------
    // state
    // -----------------------------------------------
    typedef struct packed {
        logic [WIDTH-1:0] prev;
    } rd_state_t;

    rd_state_t st_r;
    rd_state_t st_nxt;

    if (WIDTH < 1) begin : g_chk
        $error("rise_detect: WIDTH must be at least 1");
    end

    always_comb begin
        st_nxt = st_r;
        st_nxt.prev = level;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_r <= '0;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    // a level held high through reset is seen as one edge after release
    assign rise = level & ~st_r.prev;
endmodule

//--- logic/interrupt_event_reg.sv
`timescale 1ns/1ps
module interrupt_event_reg #(
    parameter int N_CTX = 4,
    parameter longint OVERLONG_CYCLES = event_reg_pkg::OVERLONG_CYCLES
) (
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic CE,
    // register port
    input wire logic [event_reg_pkg::ADDR_W-1:0] REG_ADDR,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [31:0] REG_WDATA,
    output logic [31:0] REG_RDATA,
    input wire logic [31:0] INTERRUPT_ENABLE_MASK_REG,
    output logic IRQ,
    // event sources
    input wire logic PHY_REG_BYTE_ARRIVED,
    input wire logic CYCLE_MASTER_ENABLE,
    output logic CYCLE_MASTER_CLEAR,
    input wire logic CYCLE_START_SENT,
    input wire logic CYCLE_START_RCVD,
    input wire logic SUBACTION_GAP,
    input wire logic BUS_RESET,
    input wire logic [N_CTX-1:0] CONTEXT_HALTED_FLAG,
    output logic [N_CTX-1:0] CONTEXT_EVENT_BLOCK,
    input wire logic [event_reg_pkg::SECONDS_W-1:0] RX_SECONDS,
    input wire logic [event_reg_pkg::COUNT_W-1:0] RX_COUNT,
    input wire logic [event_reg_pkg::SECONDS_W-1:0] TIMER_SECONDS_FIELD,
    input wire logic [event_reg_pkg::COUNT_W-1:0] TIMER_COUNT_FIELD,
    input wire logic TIMER_HOST_WRITE,
    input wire logic [event_reg_pkg::SECONDS_W-1:0] TIMER_WR_SECONDS,
    input wire logic [event_reg_pkg::COUNT_W-1:0] TIMER_WR_COUNT
);
    // -----------------------------------------------
    // parameter checks
    // -----------------------------------------------
    if (N_CTX < 1) begin : g_chk_ctx
        $error("interrupt_event_reg: N_CTX must be at least 1");
    end
    if (OVERLONG_CYCLES < 1 || OVERLONG_CYCLES >= (64'd1 << event_reg_pkg::OVERLONG_CNT_W))
    begin : g_chk_ovl
        $error("interrupt_event_reg: OVERLONG_CYCLES out of counter range");
    end

    localparam logic [event_reg_pkg::OVERLONG_CNT_W-1:0] OVL_LAST =
        event_reg_pkg::OVERLONG_CNT_W'(OVERLONG_CYCLES - 64'd1);

    // -----------------------------------------------
    // state
    // -----------------------------------------------
    typedef struct packed {
        logic [event_reg_pkg::EV_N-1:0] events;
        logic [N_CTX-1:0] cause;
        logic [event_reg_pkg::OVERLONG_CNT_W-1:0] ovl_cnt;
        logic ovl_run;
        logic start_seen;
        logic primed;
        logic count_lsb_d;
        logic sec_roll_d;
        logic cm_clear;
        logic [31:0] rdata;
    } ev_state_t;

    ev_state_t st_r;
    ev_state_t st_nxt;

    // -----------------------------------------------
    // source signals
    // -----------------------------------------------
    logic [event_reg_pkg::EV_N-1:0] src_level;
    logic [event_reg_pkg::EV_N-1:0] src_rise;
    logic [N_CTX-1:0] halt_rise;
    logic ovl_fire;
    logic cycle_sync_event;
    logic roll_change;
    logic start_any;
    logic rx_mismatch;
    logic wr_mismatch;
    logic [31:0] event_word;
    logic [31:0] masked_word;
    logic [event_reg_pkg::EV_N-1:0] sw_set;
    logic [event_reg_pkg::EV_N-1:0] sw_clr;
    logic [event_reg_pkg::EV_N-1:0] hw_set;
    logic wr_set_addr;
    logic wr_clr_addr;

    rise_detect #(
        .WIDTH(N_CTX)
    ) u_halt_rise (
        .clk_sys(CLK_SYS),
        .rst(RST),
        .ce(CE),
        .level(CONTEXT_HALTED_FLAG),
        .rise(halt_rise)
    );

    rise_detect #(
        .WIDTH(event_reg_pkg::EV_N)
    ) u_src_rise (
        .clk_sys(CLK_SYS),
        .rst(RST),
        .ce(CE),
        .level(src_level),
        .rise(src_rise)
    );

    assign ovl_fire = st_r.ovl_run && (st_r.ovl_cnt == OVL_LAST);
    // the first cycle after reset only samples, so a stale lsb makes no sync
    assign cycle_sync_event = st_r.primed &&
        (TIMER_COUNT_FIELD[0] != st_r.count_lsb_d);
    assign roll_change = st_r.primed &&
        (TIMER_SECONDS_FIELD[event_reg_pkg::SECONDS_ROLL_BIT] != st_r.sec_roll_d);
    assign start_any = CYCLE_START_SENT || CYCLE_START_RCVD;
    assign rx_mismatch = CYCLE_START_RCVD &&
        ((RX_SECONDS != TIMER_SECONDS_FIELD) || (RX_COUNT != TIMER_COUNT_FIELD));
    assign wr_mismatch = TIMER_HOST_WRITE &&
        ((TIMER_WR_SECONDS != TIMER_SECONDS_FIELD) ||
         (TIMER_WR_COUNT != TIMER_COUNT_FIELD));

    always_comb begin
        src_level = '0;
        src_level[event_reg_pkg::BIT_PHY_REG - event_reg_pkg::EV_LO] =
            PHY_REG_BYTE_ARRIVED;
        src_level[event_reg_pkg::BIT_OVERLONG - event_reg_pkg::EV_LO] =
            ovl_fire && CYCLE_MASTER_ENABLE;
        src_level[event_reg_pkg::BIT_FATAL - event_reg_pkg::EV_LO] = |halt_rise;
        src_level[event_reg_pkg::BIT_MISMATCH - event_reg_pkg::EV_LO] =
            rx_mismatch || wr_mismatch;
        src_level[event_reg_pkg::BIT_MISSING - event_reg_pkg::EV_LO] =
            cycle_sync_event && !st_r.start_seen && !start_any;
        src_level[event_reg_pkg::BIT_SIXTY_FOUR - event_reg_pkg::EV_LO] = roll_change;
    end

    // -----------------------------------------------
    // register port decode
    // -----------------------------------------------
    assign wr_set_addr = REG_WR && (REG_ADDR == event_reg_pkg::OFS_EVENT_SET);
    assign wr_clr_addr = REG_WR && (REG_ADDR == event_reg_pkg::OFS_EVENT_CLR);
    // only ones act; bits outside 26:21 belong to other logic
    assign sw_set = wr_set_addr ?
        REG_WDATA[event_reg_pkg::EV_HI:event_reg_pkg::EV_LO] : '0;
    assign sw_clr = wr_clr_addr ?
        REG_WDATA[event_reg_pkg::EV_HI:event_reg_pkg::EV_LO] : '0;
    assign hw_set = src_rise;

    always_comb begin
        event_word = event_reg_pkg::EVENT_RESET;
        event_word[event_reg_pkg::EV_HI:event_reg_pkg::EV_LO] = st_r.events;
    end
    assign masked_word = event_word & INTERRUPT_ENABLE_MASK_REG;

    // -----------------------------------------------
    // next state
    // -----------------------------------------------
    always_comb begin
        st_nxt = st_r;
        // a hardware edge in the same cycle as a clear keeps the bit
        st_nxt.events = (st_r.events & ~(sw_clr & ~hw_set)) | hw_set | sw_set;

        // causes live only as long as the fatal bit stands
        if (st_nxt.events[event_reg_pkg::BIT_FATAL - event_reg_pkg::EV_LO]) begin
            st_nxt.cause = st_r.cause | halt_rise;
        end else begin
            st_nxt.cause = '0;
        end

        if (BUS_RESET || SUBACTION_GAP) begin
            st_nxt.ovl_run = 1'b0;
            st_nxt.ovl_cnt = '0;
        end else if (CYCLE_START_SENT) begin
            st_nxt.ovl_run = 1'b1;
            st_nxt.ovl_cnt = '0;
        end else if (ovl_fire) begin
            st_nxt.ovl_run = 1'b0;
            st_nxt.ovl_cnt = '0;
        end else if (st_r.ovl_run) begin
            st_nxt.ovl_cnt = st_r.ovl_cnt + 1'b1;
        end
        // clear request is only raised when the event really counts
        st_nxt.cm_clear = ovl_fire && CYCLE_MASTER_ENABLE;

        st_nxt.primed = 1'b1;
        st_nxt.count_lsb_d = TIMER_COUNT_FIELD[0];
        st_nxt.sec_roll_d = TIMER_SECONDS_FIELD[event_reg_pkg::SECONDS_ROLL_BIT];
        // a start in the sync cycle counts toward the interval it opens
        if (cycle_sync_event) begin
            st_nxt.start_seen = start_any;
        end else if (start_any) begin
            st_nxt.start_seen = 1'b1;
        end

        if (REG_RD) begin
            case (REG_ADDR)
                event_reg_pkg::OFS_EVENT_SET: begin
                    st_nxt.rdata = event_word;
                end
                event_reg_pkg::OFS_EVENT_CLR: begin
                    st_nxt.rdata = masked_word;
                end
                default: begin
                    st_nxt.rdata = 32'h0000_0000;
                end
            endcase
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            st_r <= '0;
        end else if (CE) begin
            st_r <= st_nxt;
        end
    end

    // -----------------------------------------------
    // outputs
    // -----------------------------------------------
    assign REG_RDATA = st_r.rdata;
    assign IRQ = |masked_word;
    assign CYCLE_MASTER_CLEAR = st_r.cm_clear;
    assign CONTEXT_EVENT_BLOCK =
        st_r.cause & {N_CTX{st_r.events[event_reg_pkg::BIT_FATAL - event_reg_pkg::EV_LO]}};
endmodule

//--- bench/interrupt_event_reg_properties.sv
`timescale 1ns/1ps
module interrupt_event_reg_properties #(
    parameter int N_CTX = 4
) (
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic CE,
    input wire logic [event_reg_pkg::ADDR_W-1:0] REG_ADDR,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [31:0] REG_WDATA,
    input wire logic [31:0] REG_RDATA,
    input wire logic [31:0] INTERRUPT_ENABLE_MASK_REG,
    input wire logic IRQ,
    input wire logic CYCLE_MASTER_CLEAR,
    input wire logic [N_CTX-1:0] CONTEXT_HALTED_FLAG,
    input wire logic [N_CTX-1:0] CONTEXT_EVENT_BLOCK,
    input wire logic [event_reg_pkg::SECONDS_W-1:0] TIMER_SECONDS_FIELD
);
    // ----------
    // shorthands
    // ----------
    localparam logic [7:0] AS = event_reg_pkg::OFS_EVENT_SET;
    localparam logic [7:0] AC = event_reg_pkg::OFS_EVENT_CLR;
    wire [31:0] m = INTERRUPT_ENABLE_MASK_REG;
    wire rd = CE && REG_RD;
    wire bad = rd && REG_ADDR != AS && REG_ADDR != AC;
    // ----------
    // properties
    // ----------
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    // a mask change excuses the irq, since irq follows the mask at once
    a_set_irq: assert property (CE && REG_WR && REG_ADDR == AS &&
        (REG_WDATA[26:21] & m[26:21]) != 6'h00 |=> IRQ || !$stable(m)) else $error("irq late");
    a_clear_masked: assert property (rd && REG_ADDR == AC |=>
        (REG_RDATA & ~$past(m)) == 32'h0) else $error("clear read unmasked");
    a_rdata_hold: assert property (!rd |=> $stable(REG_RDATA))
        else $error("read data moved");
    a_unmapped_zero: assert property (bad |=> REG_RDATA == 32'h0)
        else $error("unmapped read not zero");
    a_clear_pulse: assert property (CYCLE_MASTER_CLEAR |=> !CYCLE_MASTER_CLEAR)
        else $error("clear pulse too long");
    a_halt_block: assert property (CE && $rose(CONTEXT_HALTED_FLAG[1])
        |=> CONTEXT_EVENT_BLOCK[1]) else $error("halt not blocked");
    a_mask_quiet: assert property (m == 32'h0 |-> !IRQ) else $error("irq unmasked");
    a_tick_irq: assert property (CE && !$past(RST) && m[21] &&
        $changed(TIMER_SECONDS_FIELD[6]) |=> IRQ || !$stable(m)) else $error("tick missed");
    c_fire: cover property (CYCLE_MASTER_CLEAR);
    c_clear_read: cover property (rd && REG_ADDR == AC);
    c_block: cover property (CONTEXT_EVENT_BLOCK != '0);
endmodule

//--- bench/interrupt_event_reg_tb.sv
`timescale 1ns/1ps
module interrupt_event_reg_tb;
    // ----------
    // setup
    // ----------
    localparam int OV = 50; // short overlong count keeps the run brief
    localparam logic [31:0] ALL = 32'hFFFFFFFF;
    localparam logic [7:0] S = event_reg_pkg::OFS_EVENT_SET;
    localparam logic [7:0] C = event_reg_pkg::OFS_EVENT_CLR;
    logic clk = 1'h0, rst = 1'h1, ce = 1'h1, wr = 1'h0, rd = 1'h0, phy = 1'h0, cme = 1'h0;
    logic css = 1'h0, csr = 1'h0, sag = 1'h0, brst = 1'h0, thw = 1'h0, irq, cmc;
    logic [7:0] addr = 8'h00;
    logic [31:0] wd = 32'h0, mask = 32'h07E00000, rdat;
    logic [3:0] halt = 4'h0, blk;
    logic [6:0] rxs = 7'h00, ts = 7'h00, tws = 7'h00;
    logic [12:0] rxc = 13'h0000, tc = 13'h0000, twc = 13'h0000;
    int err_count = 0;
    int num_checks = 0;
    int n;
    // set, clear, mask, expected raw
    logic [31:0] t [4][4] = '{'{32'h07E00000, 32'h0, 32'h07E00000, 32'h07E00000},
        '{32'h07E00000, 32'h02A00000, 32'h04200000, 32'h05400000},
        '{ALL, 32'h0, ALL, 32'h07E00000}, '{32'h00200000, 32'h0, 32'h0, 32'h00200000}};
    always #2.5 clk = ~clk;
    interrupt_event_reg #(.OVERLONG_CYCLES(OV)) uut (.CLK_SYS(clk), .RST(rst), .CE(ce),
        .REG_ADDR(addr), .REG_WR(wr), .REG_RD(rd), .REG_WDATA(wd), .REG_RDATA(rdat),
        .INTERRUPT_ENABLE_MASK_REG(mask), .IRQ(irq), .PHY_REG_BYTE_ARRIVED(phy),
        .CYCLE_MASTER_ENABLE(cme), .CYCLE_MASTER_CLEAR(cmc), .CYCLE_START_SENT(css),
        .CYCLE_START_RCVD(csr), .SUBACTION_GAP(sag), .BUS_RESET(brst),
        .CONTEXT_HALTED_FLAG(halt), .CONTEXT_EVENT_BLOCK(blk), .RX_SECONDS(rxs),
        .RX_COUNT(rxc), .TIMER_SECONDS_FIELD(ts), .TIMER_COUNT_FIELD(tc),
        .TIMER_HOST_WRITE(thw), .TIMER_WR_SECONDS(tws), .TIMER_WR_COUNT(twc));
    // ----------
    // tasks
    // ----------
    task automatic chk(input string s, input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %s exp %h got %h", s, e, g);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'h1;
        addr <= a;
        wd <= d;
        @(posedge clk);
        wr <= 1'h0;
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [31:0] e, input string s);
        @(posedge clk);
        rd <= 1'h1;
        addr <= a;
        @(posedge clk);
        rd <= 1'h0;
        #1 chk(s, rdat, e);
    endtask
    task automatic ev(input logic [31:0] e);
        rd_reg(S, e, "events");
        wr_reg(C, ALL);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // ----------
    // sequence
    // ----------
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'h0;
        rd_reg(S, 32'h0, "reset");
        foreach (t[i]) begin
            @(posedge clk);
            mask <= t[i][2];
            wr_reg(C, ALL);
            wr_reg(S, t[i][0]);
            wr_reg(C, t[i][1]);
            rd_reg(S, t[i][3], "raw");
            rd_reg(C, t[i][3] & t[i][2], "masked");
            chk("irq", {31'h0, irq}, {31'h0, |(t[i][3] & t[i][2])});
        end
        @(posedge clk);
        mask <= 32'h07E00000;
        wr_reg(C, ALL);
        wr_reg(8'h88, ALL);
        rd_reg(S, 32'h0, "stray write");
        rd_reg(8'h88, 32'h0, "unmapped");
        @(posedge clk);
        phy <= 1'h1;
        ev(32'h04000000);
        ev(32'h0);
        @(posedge clk);
        phy <= 1'h0;
        // edge and clear must meet at the same clock edge
        @(posedge clk);
        phy <= 1'h1;
        wr <= 1'h1;
        addr <= C;
        wd <= 32'h04000000;
        @(posedge clk);
        wr <= 1'h0;
        ev(32'h04000000);
        phy <= 1'h0;
        ts <= 7'h40;
        ev(32'h00200000);
        ts <= 7'h41;
        ev(32'h0);
        tc <= 13'h0001;
        css <= 1'h1;
        @(posedge clk);
        css <= 1'h0;
        wr_reg(C, ALL);
        tc <= 13'h0000;
        ev(32'h0);
        tc <= 13'h0001;
        ev(32'h00400000);
        rxs <= 7'h41;
        rxc <= 13'h0001;
        csr <= 1'h1;
        @(posedge clk);
        csr <= 1'h0;
        ev(32'h0);
        rxc <= 13'h0002;
        csr <= 1'h1;
        @(posedge clk);
        csr <= 1'h0;
        ev(32'h00800000);
        thw <= 1'h1;
        tws <= 7'h42;
        twc <= 13'h0001;
        @(posedge clk);
        thw <= 1'h0;
        ev(32'h00800000);
        halt <= 4'h2;
        repeat (2) @(posedge clk);
        #1 chk("block", {28'h0, blk}, 32'h2);
        ev(32'h01000000);
        #1 chk("block", {28'h0, blk}, 32'h0);
        // let any overlong count from the earlier start run out first
        repeat (OV) @(posedge clk);
        cme <= 1'h1;
        css <= 1'h1;
        @(posedge clk);
        css <= 1'h0;
        n = 0;
        while (!cmc && n < 200) begin
            @(posedge clk);
            #1 n++;
        end
        chk("fire", {31'h0, n >= OV && n <= OV + 3}, 32'h1);
        ev(32'h02000000);
        cme <= 1'h0;
        css <= 1'h1;
        @(posedge clk);
        css <= 1'h0;
        repeat (OV + 5) @(posedge clk);
        ev(32'h0);
        cme <= 1'h1;
        css <= 1'h1;
        @(posedge clk);
        css <= 1'h0;
        sag <= 1'h1;
        @(posedge clk);
        sag <= 1'h0;
        repeat (OV + 5) @(posedge clk);
        ev(32'h0);
        // reset in mid-run with events and a halt pending
        cme <= 1'h0;
        wr_reg(S, 32'h07E00000);
        @(posedge clk);
        rst <= 1'h1;
        halt <= 4'h0;
        repeat (2) @(posedge clk);
        rst <= 1'h0;
        rd_reg(S, 32'h0, "mid reset");
        chk("reset block", {28'h0, blk}, 32'h0);
        chk("reset irq", {31'h0, irq}, 32'h0);
        tally_and_finish();
    end
    // the sequence needs well under 2000 cycles
    initial begin
        #50000;
        err_count++;
        tally_and_finish();
    end
endmodule
bind interrupt_event_reg interrupt_event_reg_properties #(.N_CTX(N_CTX)) props (
    .CLK_SYS(CLK_SYS), .RST(RST), .CE(CE), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR),
    .REG_RD(REG_RD), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
    .INTERRUPT_ENABLE_MASK_REG(INTERRUPT_ENABLE_MASK_REG), .IRQ(IRQ),
    .CYCLE_MASTER_CLEAR(CYCLE_MASTER_CLEAR), .CONTEXT_HALTED_FLAG(CONTEXT_HALTED_FLAG),
    .CONTEXT_EVENT_BLOCK(CONTEXT_EVENT_BLOCK), .TIMER_SECONDS_FIELD(TIMER_SECONDS_FIELD));
